//--- include/adcsr_pkg.sv
// ============================================================
// Shared constants for start control and serial readout
package adcsr_pkg;

  // ============================================================
  // Rate selection
  localparam int RATE_W = 3;
  localparam logic [2:0] RATE_HS_2M = 3'h4;
  localparam logic [2:0] RATE_HS_4M = 3'h5;

  // ============================================================
  // Data path
  localparam int WORD_W = 24;
  localparam int FIFO_DEPTH = 4;
  localparam int BIT_CNT_W = 5;
  localparam logic [4:0] LAST_BIT = 5'h17;
  localparam int HALF_CNT_W = 6;
  localparam logic [5:0] LAST_HALF = 6'h2f;

  // ============================================================
  // Pin bundle layout after synchronisation
  localparam int PIN_W = 8;
  localparam int PIN_START = 0;
  localparam int PIN_CS_N = 1;
  localparam int PIN_RATE_LO = 2;
  localparam int PIN_LVDS_N = 5;
  localparam int PIN_SCLK_SEL = 6;
  localparam int PIN_POWER_DOWN_PIN = 7;

  // ============================================================
  // Timing
  localparam int SYS_CLK_PERIOD_NS = 50;
  localparam int RESULT_READY_STROBE_PULSE_TCLK = 1;
  localparam int RESULT_READY_STROBE_PULSE_CYC = RESULT_READY_STROBE_PULSE_TCLK;
  localparam int SETTLE_DEFAULT_CYC = 16;
  localparam int SETTLE_CNT_W = 12;
  localparam int ORNG_DEFAULT_RUN = 8;
  localparam int ORNG_CNT_W = 8;

  // ============================================================
  // Conversion control states
  typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_RUN} adcsr_conv_t;

endpackage : adcsr_pkg

//--- src/adcsr_sync.sv
`timescale 1ns/100ps
// ============================================================
// Two-stage synchroniser for a bundle of static or slow levels
module adcsr_sync #(
  parameter int W = 1
) (
  input wire logic clk, // Destination clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [W-1:0] din, // Level from another domain
  output logic [W-1:0] dout // Synchronised level
);

  logic [W-1:0] meta;

  // Meta stage is read only by the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule : adcsr_sync

//--- src/adcsr_fifo.sv
`timescale 1ns/100ps
// ============================================================
// Small synchronous FIFO with flush
module adcsr_fifo #(
  parameter int W = 24,
  parameter int D = 4
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic flush, // Drops all words
  input wire logic in_valid, // Write request
  output logic in_ready, // Room available
  input wire logic [W-1:0] in_data, // Write word
  output logic out_valid, // Word available
  input wire logic out_ready, // Read request
  output logic [W-1:0] out_data // Oldest word
);

  localparam int AW = (D > 1) ? $clog2(D) : 1;

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire do_wr = in_valid && in_ready;
  wire do_rd = out_valid && out_ready;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : ptr_inc

  assign in_ready = (count != (AW + 1)'(D));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_wr) wr_ptr <= ptr_inc(wr_ptr);
      if (do_rd) rd_ptr <= ptr_inc(rd_ptr);
      if (do_wr && !do_rd) count <= count + 1'b1;
      else if (do_rd && !do_wr) count <= count - 1'b1;
    end
  end

endmodule : adcsr_fifo

//--- src/adcsr_top.sv
`timescale 1ns/100ps
module adcsr_top #(
  parameter int SETTLE_CYC = adcsr_pkg::SETTLE_DEFAULT_CYC,
  parameter int ORNG_RUN = adcsr_pkg::ORNG_DEFAULT_RUN
) (
  input wire logic sys_clk, // Master clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic start, // Start pin
  input wire logic cs_n, // Chip select pin, active low
  input wire logic [2:0] rate_select, // Data rate pins
  input wire logic lvds_sel_n, // Low selects LVDS, high CMOS
  input wire logic sclk_sel, // Shift clock source select pin
  input wire logic power_down_pin, // Power-down pin, active high
  input wire logic [23:0] sample_data, // Filtered result
  input wire logic sample_valid, // Result strobe from filter
  input wire logic input_overrange_flag, // Modulator overrange with result
  output logic sample_ready, // Result accepted this cycle
  input wire logic link_sclk, // Host shift clock
  output logic sclk_out, // Generated shift clock
  output logic sclk_oe, // Shift clock pin driven
  output logic dout, // Serial data
  output logic dout_oe, // Serial data pin driven
  output logic result_ready_strobe, // Data ready pulse
  output logic filter_overrange_flag, // Sustained overrange
  output logic high_speed_mode // High-speed rate selected
);

  // ============================================================
  // Pin synchronisation
  logic [adcsr_pkg::PIN_W-1:0] pins_s;
  wire [adcsr_pkg::PIN_W-1:0] pins_raw = {power_down_pin, sclk_sel, lvds_sel_n, rate_select, cs_n, start};

  // Configuration lives on pins only
  adcsr_sync #(.W(adcsr_pkg::PIN_W)) u_pin_sync (
    .clk(sys_clk),
    .rst_n(rst_n),
    .din(pins_raw),
    .dout(pins_s)
  );

  wire start_s = pins_s[adcsr_pkg::PIN_START];
  wire cs_n_s = pins_s[adcsr_pkg::PIN_CS_N];
  wire [2:0] rate_s = pins_s[adcsr_pkg::PIN_RATE_LO +: adcsr_pkg::RATE_W];
  wire cmos_s = pins_s[adcsr_pkg::PIN_LVDS_N];
  wire sclk_sel_s = pins_s[adcsr_pkg::PIN_SCLK_SEL];
  wire pd_s = pins_s[adcsr_pkg::PIN_POWER_DOWN_PIN];

  function automatic logic is_high_speed(input logic [2:0] code);
    is_high_speed = (code == adcsr_pkg::RATE_HS_2M) || (code == adcsr_pkg::RATE_HS_4M);
  endfunction : is_high_speed

  // ============================================================
  // Mode decode
  wire hs_now = is_high_speed(rate_s);
  wire ext_mode = cmos_s && sclk_sel_s;
  wire rate_ok = !(cmos_s && hs_now);

  logic start_d;
  wire start_rise = start_s && !start_d;

  // ============================================================
  // Conversion control
  adcsr_pkg::adcsr_conv_t state;
  adcsr_pkg::adcsr_conv_t next_state;
  logic [adcsr_pkg::SETTLE_CNT_W-1:0] settle_cnt;
  wire settle_done = (settle_cnt == adcsr_pkg::SETTLE_CNT_W'(SETTLE_CYC - 1));
  wire fifo_in_ready;
  wire push = sample_valid && (state == adcsr_pkg::ST_RUN) && rate_ok && !pd_s && fifo_in_ready;
  // A restart flushes the unread words of the old conversion
  wire flush = start_rise || pd_s;

  assign sample_ready = push;

  always_comb begin
    next_state = state;
    case (state)
      adcsr_pkg::ST_IDLE: begin
        if (start_rise) next_state = adcsr_pkg::ST_SETTLE;
      end
      adcsr_pkg::ST_SETTLE: begin
        if (settle_done) next_state = adcsr_pkg::ST_RUN;
      end
      adcsr_pkg::ST_RUN: begin
        // Holding start high keeps converting; a pulse gives one result
        if (push && !start_s) next_state = adcsr_pkg::ST_IDLE;
      end
      default: next_state = adcsr_pkg::ST_IDLE;
    endcase
    if (start_rise) next_state = adcsr_pkg::ST_SETTLE;
    if (pd_s) next_state = adcsr_pkg::ST_IDLE;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= adcsr_pkg::ST_IDLE;
      start_d <= 1'b0;
      settle_cnt <= '0;
      high_speed_mode <= 1'b0;
    end else begin
      state <= next_state;
      start_d <= start_s;
      settle_cnt <= (state == adcsr_pkg::ST_SETTLE && !start_rise) ? settle_cnt + 1'b1 : '0;
      high_speed_mode <= hs_now;
    end
  end

  // ============================================================
  // Overrange run detector
  logic [adcsr_pkg::ORNG_CNT_W-1:0] orng_cnt;
  wire orng_hit = (orng_cnt == adcsr_pkg::ORNG_CNT_W'(ORNG_RUN - 1));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      orng_cnt <= '0;
      filter_overrange_flag <= 1'b0;
    end else if (pd_s) begin
      orng_cnt <= '0;
      filter_overrange_flag <= 1'b0;
    end else if (push) begin
      if (!input_overrange_flag) begin
        orng_cnt <= '0;
        filter_overrange_flag <= 1'b0;
      end else if (orng_hit) begin
        filter_overrange_flag <= 1'b1;
      end else begin
        orng_cnt <= orng_cnt + 1'b1;
      end
    end
  end

  // ============================================================
  // Result buffer
  wire fifo_out_valid;
  wire [adcsr_pkg::WORD_W-1:0] fifo_out_data;
  logic rd_busy;
  logic ext_wait;
  logic busy_seen;
  wire link_busy_s;
  // Link busy only gates the host-clocked path; the generated clock also runs the link counter
  wire link_hold = ext_mode && link_busy_s;
  wire pop = fifo_out_valid && !rd_busy && !ext_wait && !link_hold && !pd_s;

  adcsr_fifo #(.W(adcsr_pkg::WORD_W), .D(adcsr_pkg::FIFO_DEPTH)) u_fifo (
    .clk(sys_clk),
    .rst_n(rst_n),
    .flush(flush),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(sample_data),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data)
  );

  // ============================================================
  // Internal shift clock readout
  logic [adcsr_pkg::WORD_W-1:0] hold_word;
  logic [adcsr_pkg::WORD_W-1:0] shift_int;
  logic [adcsr_pkg::HALF_CNT_W-1:0] half_cnt;
  logic sclk_int;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_word <= '0;
      shift_int <= '0;
      half_cnt <= '0;
      sclk_int <= 1'b0;
      rd_busy <= 1'b0;
      result_ready_strobe <= 1'b0;
    end else if (pd_s) begin
      sclk_int <= 1'b0;
      rd_busy <= 1'b0;
      result_ready_strobe <= 1'b0;
    end else begin
      result_ready_strobe <= pop;
      if (pop) begin
        hold_word <= fifo_out_data;
      end
      if (pop && !ext_mode) begin
        shift_int <= fifo_out_data;
        half_cnt <= '0;
        rd_busy <= 1'b1;
      end else if (rd_busy) begin
        sclk_int <= !sclk_int;
        half_cnt <= half_cnt + 1'b1;
        // Shift on every rising edge but the first
        if (!sclk_int && half_cnt != '0) shift_int <= {shift_int[adcsr_pkg::WORD_W-2:0], 1'b0};
        if (half_cnt == adcsr_pkg::LAST_HALF) rd_busy <= 1'b0;
      end
    end
  end

  // ============================================================
  // External shift clock handshake
  // Waits for the host to start and finish a word; a host that never reads stalls the buffer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_wait <= 1'b0;
      busy_seen <= 1'b0;
    end else if (pd_s || !ext_mode) begin
      ext_wait <= 1'b0;
      busy_seen <= 1'b0;
    end else if (pop) begin
      ext_wait <= 1'b1;
      busy_seen <= 1'b0;
    end else if (ext_wait) begin
      if (link_busy_s) busy_seen <= 1'b1;
      if (busy_seen && !link_busy_s) ext_wait <= 1'b0;
    end
  end

  // ============================================================
  // Link domain, clocked by the host shift clock
  // Chip select high ends the frame, since the host clock stops between frames
  wire link_rst_n = rst_n && !cs_n;
  logic [adcsr_pkg::BIT_CNT_W-1:0] link_cnt;
  logic [adcsr_pkg::WORD_W-1:0] shift_ext;
  logic link_busy;

  // The held word is still while the sys side waits, so the first edge reads it directly
  always_ff @(posedge link_sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      link_cnt <= '0;
      shift_ext <= '0;
      link_busy <= 1'b0;
    end else if (link_cnt == '0) begin
      shift_ext <= hold_word;
      link_cnt <= 5'h01;
      link_busy <= 1'b1;
    end else begin
      shift_ext <= {shift_ext[adcsr_pkg::WORD_W-2:0], 1'b0};
      link_cnt <= (link_cnt == adcsr_pkg::LAST_BIT) ? '0 : link_cnt + 1'b1;
      if (link_cnt == adcsr_pkg::LAST_BIT) link_busy <= 1'b0;
    end
  end

  adcsr_sync #(.W(1)) u_busy_sync (
    .clk(sys_clk),
    .rst_n(rst_n),
    .din(link_busy),
    .dout(link_busy_s)
  );

  // ============================================================
  // Pin drivers
  assign sclk_out = sclk_int;
  assign sclk_oe = !sclk_sel_s && !pd_s;
  assign dout = ext_mode ? shift_ext[adcsr_pkg::WORD_W-1] : shift_int[adcsr_pkg::WORD_W-1];
  assign dout_oe = !cs_n_s && !pd_s;

  // ============================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence result_ready_strobe_int_s;
    result_ready_strobe && !ext_mode;
  endsequence

  sequence first_rise_s;
    ##1 sclk_out ##1 !sclk_out;
  endsequence

  AST_HS_DECODE: assert property (high_speed_mode == $past(is_high_speed(rate_s)))
    else $error("high speed flag does not follow rate code");
  AST_LS_DECODE: assert property (!$past(is_high_speed(rate_s)) |-> !high_speed_mode)
    else $error("low speed code shows high speed");
  AST_CMOS_NO_HS: assert property (cmos_s && is_high_speed(rate_s) |-> !sample_ready)
    else $error("high speed result taken over CMOS");
  AST_EXT_NO_GEN: assert property (ext_mode && !rd_busy |=> !sclk_out)
    else $error("shift clock generated in external mode");
  AST_RESULT_READY_STROBE_PULSE: assert property (result_ready_strobe |=> !result_ready_strobe)
    else $error("data ready pulse too long");
  AST_RESULT_READY_STROBE_THEN_SCLK: assert property (result_ready_strobe_int_s |-> !sclk_out ##0 first_rise_s)
    else $error("first shift edge not after data ready");
  AST_WORD_LEN: assert property (result_ready_strobe_int_s |-> ##47 rd_busy ##1 !rd_busy && !sclk_out)
    else $error("internal readout not 24 clocks");
  AST_CS_RELEASE: assert property ($rose(cs_n_s) |-> !dout_oe)
    else $error("data driven with chip select high");
  AST_CS_ENABLE: assert property (!cs_n_s && !pd_s |-> dout_oe)
    else $error("data not driven with chip select low");
  AST_PD_QUIET: assert property (pd_s |=> state == adcsr_pkg::ST_IDLE && !result_ready_strobe && !sclk_out)
    else $error("activity during power down");
  AST_SCLK_DIR: assert property (sclk_sel_s |-> !sclk_oe)
    else $error("shift clock driven while host supplies it");
  AST_START_SAMPLE: assert property (start_rise && !pd_s |=> state == adcsr_pkg::ST_SETTLE)
    else $error("start edge not taken");
  AST_ORNG_RUN: assert property ($rose(filter_overrange_flag) |-> $past(orng_hit && push))
    else $error("overrange flag raised without full run");

endmodule : adcsr_top

//--- bench/adcsr_host.sv
`timescale 1ns/100ps
// ============================================================
// Host side: chip select and shift clock for external readout
module adcsr_host (
  input wire logic dout_line, // Serial data as seen on the wire
  output logic cs_n, // Chip select, active low
  output logic host_sclk // Host shift clock
);
  // Clock stands still low outside frames
  initial begin
    cs_n = 1'b0;
    host_sclk = 1'b0;
  end

  task automatic select();
    cs_n = 1'b0;
  endtask : select

  // Half period is a knob, so the host can be prompt or slow
  task automatic frame(input int half, output logic [23:0] v);
    cs_n = 1'b0;
    #207;
    for (int i = 0; i < 24; i++) begin
      host_sclk = 1'b1;
      #(half);
      host_sclk = 1'b0;
      v = {v[22:0], dout_line};
      #(half);
    end
    #5 cs_n = 1'b1;
  endtask : frame
endmodule : adcsr_host

//--- bench/adcsr_top_tb.sv
`timescale 1ns/100ps
module adcsr_top_tb;
  localparam int SETTLE = 2;
  localparam int ORUN = 2;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic start, lvds_sel_n, sclk_sel, power_down_pin, sample_valid, input_overrange_flag;
  logic [2:0] rate_select;
  logic [23:0] sample_data, w;
  logic a;
  logic acc [0:5];
  wire cs_n, host_sclk, link_sclk, dout_wire;
  wire sample_ready, sclk_out, sclk_oe, dout, dout_oe;
  wire result_ready_strobe, filter_overrange_flag, high_speed_mode;
  int err_count = 0;
  int checks = 0;
  int n;

  always #25 sys_clk = ~sys_clk;

  // ============================================================
  // Wire levels from all drivers
  assign link_sclk = sclk_oe ? sclk_out : host_sclk;
  assign dout_wire = dout_oe ? dout : 1'bz;

  adcsr_top #(.SETTLE_CYC(SETTLE), .ORNG_RUN(ORUN)) DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .start(start), .cs_n(cs_n),
    .rate_select(rate_select), .lvds_sel_n(lvds_sel_n), .sclk_sel(sclk_sel),
    .power_down_pin(power_down_pin), .sample_data(sample_data), .sample_valid(sample_valid),
    .input_overrange_flag(input_overrange_flag), .sample_ready(sample_ready),
    .link_sclk(link_sclk), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .dout(dout),
    .dout_oe(dout_oe), .result_ready_strobe(result_ready_strobe),
    .filter_overrange_flag(filter_overrange_flag), .high_speed_mode(high_speed_mode)
  );

  adcsr_host host (.dout_line(dout_wire), .cs_n(cs_n), .host_sclk(host_sclk));

  // ============================================================
  // Access tasks
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
    #2;
  endtask : tick

  task automatic push(input logic [23:0] d, input logic o, output logic r);
    @(posedge sys_clk);
    #2 sample_valid = 1'b1;
    sample_data = d;
    input_overrange_flag = o;
    #1 r = sample_ready;
    @(posedge sys_clk);
    #2 sample_valid = 1'b0;
  endtask : push

  task automatic burst();
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      #2 sample_valid = 1'b1;
      sample_data = 24'h100000 + 24'(i);
      input_overrange_flag = 1'b0;
      #1 acc[i] = sample_ready;
    end
    @(posedge sys_clk);
    #2 sample_valid = 1'b0;
  endtask : burst

  // Bounded wait; strobe must come before the first shift edge
  task automatic wait_strobe();
    int k;
    k = 0;
    @(posedge sys_clk);
    #1;
    while (result_ready_strobe !== 1'b1 && k < 200) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    chk(24'(k < 200), 24'h1);
    chk(sclk_out, 24'h0);
  endtask : wait_strobe

  // Host samples on each falling shift edge
  task automatic read_int(output logic [23:0] v);
    repeat (24) begin
      @(negedge link_sclk);
      v = {v[22:0], dout_wire};
    end
  endtask : read_int

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // ============================================================
  // Tests
  initial begin
    start = 1'b0;
    rate_select = 3'h0;
    lvds_sel_n = 1'b0;
    sclk_sel = 1'b0;
    power_down_pin = 1'b0;
    sample_data = 24'h000000;
    sample_valid = 1'b0;
    input_overrange_flag = 1'b0;
    repeat (4) @(posedge sys_clk);
    #2 rst_n = 1'b1;
    tick(3);
    chk(result_ready_strobe, 24'h0);
    chk(sclk_oe, 24'h1);
    chk(dout_oe, 24'h1);
    for (n = 0; n < 8; n++) begin
      rate_select = n[2:0];
      tick(4);
      chk(high_speed_mode, 24'(n == 4 || n == 5));
    end
    rate_select = 3'h0;
    start = 1'b1;
    tick(3 + SETTLE + 2);
    push(24'ha5c3e1, 1'b0, a);
    chk(a, 24'h1);
    wait_strobe();
    read_int(w);
    chk(w, 24'ha5c3e1);
    // Fill until refused while readout drains
    fork
      burst();
      for (int k = 0; k < 5; k++) begin
        wait_strobe();
        read_int(w);
        chk(w, 24'h100000 + 24'(k));
      end
    join
    for (n = 0; n < 6; n++) chk(acc[n], 24'(n < 5));
    push(24'h7fffff, 1'b1, a);
    tick(3);
    chk(filter_overrange_flag, 24'h0);
    push(24'h7fffff, 1'b1, a);
    tick(3);
    chk(filter_overrange_flag, 24'h1);
    push(24'h012345, 1'b0, a);
    tick(3);
    chk(filter_overrange_flag, 24'h0);
    tick(160);
    rate_select = 3'h5;
    tick(4);
    push(24'hc0ffee, 1'b0, a);
    chk(a, 24'h1);
    wait_strobe();
    read_int(w);
    chk(w, 24'hc0ffee);
    lvds_sel_n = 1'b1;
    tick(4);
    push(24'h0badf0, 1'b0, a);
    chk(a, 24'h0);
    rate_select = 3'h2;
    tick(4);
    push(24'h5a5a5a, 1'b0, a);
    wait_strobe();
    read_int(w);
    chk(w, 24'h5a5a5a);
    tick(4);
    sclk_sel = 1'b1;
    tick(4);
    chk(sclk_oe, 24'h0);
    push(24'h9e3779, 1'b0, a);
    wait_strobe();
    host.frame(15, w);
    chk(w, 24'h9e3779);
    tick(4);
    chk(dout_oe, 24'h0);
    push(24'h3c3c3c, 1'b0, a);
    wait_strobe();
    host.frame(40, w);
    chk(w, 24'h3c3c3c);
    tick(6);
    sclk_sel = 1'b0;
    host.select();
    power_down_pin = 1'b1;
    tick(4);
    chk(sclk_oe, 24'h0);
    chk(dout_oe, 24'h0);
    push(24'h111111, 1'b0, a);
    chk(a, 24'h0);
    power_down_pin = 1'b0;
    tick(4);
    tally_and_finish();
  end

  // ============================================================
  // Watchdog, well beyond the expected run length
  initial begin
    #300000;
    err_count++;
    $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    tally_and_finish();
  end
endmodule : adcsr_top_tb
